// ### pkg/edge_timer_pkg.sv
// Constants for the 8-bit edge capture timer: register map, field
// positions, reset values and clock and clear select codes.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
package edge_timer_pkg;
   // Register indices; byte address is four times the index
   localparam logic [15:0] IDX_MODE_CTRL  = 16'hFFBC;
   localparam logic [15:0] IDX_FALL_VALUE = 16'hFFBD;
   localparam logic [15:0] IDX_RISE_VALUE = 16'hFFBE;
   localparam logic [15:0] IDX_CLK_STOP1  = 16'hFFFA;
   localparam logic [15:0] IDX_PORT_CTRL  = 16'hFFC0;
   localparam logic [15:0] IDX_IRQ_STATUS = 16'hFFC1;
   localparam logic [15:0] IDX_IRQ_MASK   = 16'hFFC2;

   // Mode register fields
   localparam int OVF_HIGH_BIT  = 7;
   localparam int OVF_LOW_BIT   = 6;
   localparam int OVF_IRQ_BIT   = 5;
   localparam int EDGE_SEL_BIT  = 4;
   localparam int CLR_SEL_LSB   = 2;
   localparam int CLK_SEL_LSB   = 0;
   // Port control fields
   localparam int CAP_EN_BIT    = 0;
   localparam int FILT_SEL_BIT  = 1;
   // Module standby bit in the clock stop register
   localparam int STANDBY_BIT   = 3;
   // Interrupt status / mask fields
   localparam int IRQ_TIMER_BIT = 0;
   localparam int IRQ_RISE_BIT  = 1;
   localparam int IRQ_FALL_BIT  = 2;

   // Reset values
   localparam logic [7:0] MODE_RST    = 8'h00;
   localparam logic [7:0] CAP_RST     = 8'h00;
   localparam logic [7:0] COUNT_RST   = 8'h00;
   localparam logic [7:0] CLKSTOP_RST = 8'hFF;
   localparam logic [1:0] PORT_RST    = 2'h0;
   localparam logic [2:0] IRQ_RST     = 3'h0;

   // Clock select codes
   localparam logic [1:0] CKS_DIV64 = 2'h0;
   localparam logic [1:0] CKS_DIV32 = 2'h1;
   localparam logic [1:0] CKS_DIV2  = 2'h2;
   localparam logic [1:0] CKS_WDIV4 = 2'h3;
   // Clear select codes
   localparam logic [1:0] CLR_NONE  = 2'h0;
   localparam logic [1:0] CLR_FALL  = 2'h1;
   localparam logic [1:0] CLR_RISE  = 2'h2;
   localparam logic [1:0] CLR_BOTH  = 2'h3;

   // Filter depth and watch clock divide
   localparam int FILTER_DEPTH = 5;
   localparam logic [1:0] WATCH_DIV_LAST = 2'h3;
endpackage

// ### rtl/capture_filter.sv
// Five-stage agreement filter for the capture input.
// Assumes din_i is already synchronised to core_clk_i.
`timescale 1ns/10ps
module capture_filter #(
   parameter int DEPTH = edge_timer_pkg::FILTER_DEPTH
) (
   // Clock and reset
   input  wire logic core_clk_i,
   input  wire logic rst_n_i,
   // Control
   input  wire logic filter_on_i,
   input  wire logic sample_i,
   // Data
   input  wire logic din_i,
   output logic      dout_o
);
   logic [DEPTH-1:0] shift_q;

   // Latch chain advances only on the sampling clock
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         shift_q <= '0;
      end else if (sample_i) begin
         shift_q <= {shift_q[DEPTH-2:0], din_i};
      end
   end

   // Filter on: output moves only when every latch agrees, otherwise holds; filter off: output follows din_i
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         dout_o <= 1'b0;
      end else if (!filter_on_i) begin
         dout_o <= din_i;
      end else if (&shift_q) begin
         dout_o <= 1'b1;
      end else if (~|shift_q) begin
         dout_o <= 1'b0;
      end
   end

   // Filtered output never rises unless all stages were high
   filter_agree_a: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i)
      (filter_on_i && $rose(dout_o) && $past(filter_on_i))
         |-> $past(&shift_q))
      else $error("filter output rose without full agreement");
endmodule

// ### rtl/edge_capture_timer8.sv
// 8-bit up-counter with rising and falling edge capture registers,
// level-tagged overflow flags and an interrupt output.
// Assumes an Avalon-MM master on core_clk_i; the capture pin and the
// watch clock are asynchronous and are synchronised here.
//
// Summary of operation
// - Counter counts on system/64, /32, /2 or watch/4; select resets to 00.
// - Capture-enable bit 1 gives capture timer, 0 gives interval timer.
// - Counter is hidden from the bus and resets to zero.
// - A falling capture edge copies the counter into the fall register.
// - A rising capture edge copies the counter into the rise register.
// - Edge select bit picks rising (0) or falling (1) for the request.
// - Clear select: none, falling, rising or both edges clear counter.
// - Wrap while capture input high sets the high overflow flag.
// - Wrap while input low, or in interval mode, sets low overflow flag.
// - Overflow flags clear by writing 0 after reading 1; never set by bus.
// - Overflow enable bit lets an overflow set the timer request flag.
// - Capture registers are read-only and reset to zero.
// - Toggling capture enable may produce a spurious capture event.
// - In low-power modes only the watch clock source keeps counting.
// - Filter on: five serial samples must agree before output changes.
// - Module standby bit 0 stops the timer; reset value 1 runs it.
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/10ps
module edge_capture_timer8 #(
   parameter int ADDR_W = 18
) (
   // Clock and reset
   input  wire logic              core_clk_i,
   input  wire logic              rst_n_i,
   // Avalon-MM slave
   input  wire logic [ADDR_W-1:0] address_i,
   input  wire logic              read_i,
   input  wire logic              write_i,
   input  wire logic [3:0]        byteenable_i,
   input  wire logic [31:0]       writedata_i,
   output logic      [31:0]       readdata_o,
   output logic                   waitrequest_o,
   // Pins and system signals
   input  wire logic              capture_input_pin_i,
   input  wire logic              watch_clk_i,
   input  wire logic              low_power_i,
   // Interrupt
   output logic                   irq_o
);
   // Registers
   logic [7:0] mode_q;
   logic [7:0] fall_q;
   logic [7:0] rise_q;
   logic [7:0] clkstop_q;
   logic [1:0] port_q;
   logic [2:0] irq_stat_q;
   logic [2:0] irq_mask_q;
   logic [7:0] count_q;
   logic [6:0] presc_q;
   logic [1:0] ovf_armed_q;
   logic [1:0] wdiv_q;
   logic [1:0] pin_sync_q;
   logic [2:0] wclk_sync_q;
   logic       cap_prev_q;

   // Combinational helpers
   logic        run;
   logic        sys_tick;
   logic        wtick;
   logic        tick;
   logic        cap_en;
   logic        cap_level;
   logic        cap_filt;
   logic        rise_ev;
   logic        fall_ev;
   logic        clr_ev;
   logic        ovf_ev;
   logic        req_take;
   logic        wr_do;
   logic        rd_take;
   logic [15:0] idx;
   logic [1:0]  cks;
   logic [1:0]  ccl;
   logic        edge_req;
   logic        timer_req;

   assign idx      = address_i[17:2];
   assign req_take = (read_i || write_i) && waitrequest_o;
   assign wr_do    = write_i && !waitrequest_o && byteenable_i[0];
   assign rd_take  = read_i && !waitrequest_o;
   assign cks      = mode_q[edge_timer_pkg::CLK_SEL_LSB +: 2];
   assign ccl      = mode_q[edge_timer_pkg::CLR_SEL_LSB +: 2];
   assign cap_en   = port_q[edge_timer_pkg::CAP_EN_BIT];
   assign run      = clkstop_q[edge_timer_pkg::STANDBY_BIT];

   // Bus handshake: one wait cycle, then a single low cycle per request
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         waitrequest_o <= 1'b1;
      end else begin
         waitrequest_o <= !req_take;
      end
   end

   // Prescaler is free running; taps give the system dividers
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         presc_q <= 7'h00;
      end else begin
         presc_q <= presc_q + 7'h01;
      end
   end

   // Watch clock passes two flops; the third stage feeds edge detect
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         wclk_sync_q <= 3'h0;
      end else begin
         wclk_sync_q <= {wclk_sync_q[1:0], watch_clk_i};
      end
   end

   // Divide watch clock rising edges by four
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         wdiv_q <= 2'h0;
      end else if (wclk_sync_q[1] && !wclk_sync_q[2]) begin
         wdiv_q <= wdiv_q + 2'h1;
      end
   end

   assign wtick = wclk_sync_q[1] && !wclk_sync_q[2]
                  && (wdiv_q == edge_timer_pkg::WATCH_DIV_LAST);

   // Source select; system dividers stop in low-power modes
   always_comb begin
      unique case (cks)
         edge_timer_pkg::CKS_DIV64: sys_tick = &presc_q[5:0];
         edge_timer_pkg::CKS_DIV32: sys_tick = &presc_q[4:0];
         edge_timer_pkg::CKS_DIV2:  sys_tick = presc_q[0];
         edge_timer_pkg::CKS_WDIV4: sys_tick = 1'b0;
      endcase
   end
   assign tick = run && (cks == edge_timer_pkg::CKS_WDIV4 ? wtick
                         : (sys_tick && !low_power_i));

   // Capture pin passes two flops before any logic reads it
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         pin_sync_q <= 2'h0;
      end else begin
         pin_sync_q <= {pin_sync_q[0], capture_input_pin_i};
      end
   end

   // Gating by the enable means a toggle can look like an edge
   assign cap_level = pin_sync_q[1] && cap_en;

   capture_filter #(
      .DEPTH (edge_timer_pkg::FILTER_DEPTH)
   ) u_filter (
      .core_clk_i  (core_clk_i),
      .rst_n_i     (rst_n_i),
      .filter_on_i (port_q[edge_timer_pkg::FILT_SEL_BIT]),
      .sample_i    (tick),
      .din_i       (cap_level),
      .dout_o      (cap_filt)
   );

   // Edge detection on the filtered capture signal
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         cap_prev_q <= 1'b0;
      end else if (run) begin
         cap_prev_q <= cap_filt;
      end
   end

   assign rise_ev = run && cap_filt && !cap_prev_q;
   assign fall_ev = run && !cap_filt && cap_prev_q;
   always_comb begin
      unique case (ccl)
         edge_timer_pkg::CLR_NONE: clr_ev = 1'b0;
         edge_timer_pkg::CLR_FALL: clr_ev = fall_ev;
         edge_timer_pkg::CLR_RISE: clr_ev = rise_ev;
         edge_timer_pkg::CLR_BOTH: clr_ev = rise_ev || fall_ev;
      endcase
   end
   assign ovf_ev = tick && !clr_ev && (count_q == 8'hFF);

   // Counter: capture clear beats the increment, standby holds it
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         count_q <= edge_timer_pkg::COUNT_RST;
      end else if (clr_ev) begin
         count_q <= 8'h00;
      end else if (tick) begin
         count_q <= count_q + 8'h01;
      end
   end

   // Capture registers take the counter value at each edge
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         fall_q <= edge_timer_pkg::CAP_RST;
         rise_q <= edge_timer_pkg::CAP_RST;
      end else begin
         if (fall_ev) begin
            fall_q <= count_q;
         end
         if (rise_ev) begin
            rise_q <= count_q;
         end
      end
   end

   // Remember which overflow flags software has seen set; arm from the
   // returned data, since a flag set after the capture was never seen
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         ovf_armed_q <= 2'h0;
      end else if (rd_take && idx == edge_timer_pkg::IDX_MODE_CTRL) begin
         ovf_armed_q <= readdata_o[7:6];
      end else if (wr_do && idx == edge_timer_pkg::IDX_MODE_CTRL) begin
         ovf_armed_q <= 2'h0;
      end
   end

   // Mode register: flags set by hardware only, cleared by armed zero
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         mode_q <= edge_timer_pkg::MODE_RST;
      end else begin
         if (wr_do && idx == edge_timer_pkg::IDX_MODE_CTRL) begin
            mode_q[5:0] <= writedata_i[5:0];
            if (ovf_armed_q[1] && !writedata_i[7]) begin
               mode_q[7] <= 1'b0;
            end
            if (ovf_armed_q[0] && !writedata_i[6]) begin
               mode_q[6] <= 1'b0;
            end
         end
         // Set after the clear so a same-cycle event survives
         if (ovf_ev && cap_en && cap_filt) begin
            mode_q[edge_timer_pkg::OVF_HIGH_BIT] <= 1'b1;
         end
         if (ovf_ev && !(cap_en && cap_filt)) begin
            mode_q[edge_timer_pkg::OVF_LOW_BIT] <= 1'b1;
         end
      end
   end

   // Port control and module standby registers
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         port_q    <= edge_timer_pkg::PORT_RST;
         clkstop_q <= edge_timer_pkg::CLKSTOP_RST;
      end else if (wr_do) begin
         if (idx == edge_timer_pkg::IDX_PORT_CTRL) begin
            port_q <= writedata_i[1:0];
         end
         if (idx == edge_timer_pkg::IDX_CLK_STOP1) begin
            clkstop_q <= writedata_i[7:0];
         end
      end
   end

   // Request sources: selected capture edge or enabled overflow
   assign edge_req  = cap_en && (mode_q[edge_timer_pkg::EDGE_SEL_BIT]
                                 ? fall_ev : rise_ev);
   assign timer_req = edge_req
                      || (ovf_ev && mode_q[edge_timer_pkg::OVF_IRQ_BIT]);

   // Sticky status, write one to clear; a new event wins over the clear
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         irq_stat_q <= edge_timer_pkg::IRQ_RST;
         irq_mask_q <= edge_timer_pkg::IRQ_RST;
      end else begin
         if (wr_do && idx == edge_timer_pkg::IDX_IRQ_MASK) begin
            irq_mask_q <= writedata_i[2:0];
         end
         irq_stat_q <= (irq_stat_q
                        & ~((wr_do && idx == edge_timer_pkg::IDX_IRQ_STATUS)
                            ? writedata_i[2:0] : 3'h0))
                       | {fall_ev && cap_en, rise_ev && cap_en,
                          timer_req};
      end
   end

   // Level interrupt from a flop; mask bit 0 is the timer enable
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(irq_stat_q & irq_mask_q);
      end
   end

   // Read data captured when the request is first seen
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         readdata_o <= 32'h0000_0000;
      end else if (read_i && waitrequest_o) begin
         unique case (idx)
            edge_timer_pkg::IDX_MODE_CTRL:  readdata_o <= {24'h0, mode_q};
            edge_timer_pkg::IDX_FALL_VALUE: readdata_o <= {24'h0, fall_q};
            edge_timer_pkg::IDX_RISE_VALUE: readdata_o <= {24'h0, rise_q};
            edge_timer_pkg::IDX_CLK_STOP1:  readdata_o <= {24'h0, clkstop_q};
            edge_timer_pkg::IDX_PORT_CTRL:  readdata_o <= {30'h0, port_q};
            edge_timer_pkg::IDX_IRQ_STATUS: readdata_o <= {29'h0, irq_stat_q};
            edge_timer_pkg::IDX_IRQ_MASK:   readdata_o <= {29'h0, irq_mask_q};
            default:                        readdata_o <= 32'h0000_0000;
         endcase
      end
   end

   // Checks
   count_wrap_a: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i)
      (tick && !clr_ev) |=> count_q == $past(count_q) + 8'h01)
      else $error("counter did not advance on tick");
   standby_hold_a: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i)
      !run |=> $stable(count_q))
      else $error("counter moved in standby");
   fall_cap_a: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i)
      fall_ev |=> fall_q == $past(count_q))
      else $error("falling capture value wrong");
   rise_cap_a: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i)
      rise_ev |=> rise_q == $past(count_q))
      else $error("rising capture value wrong");
   clear_edge_a: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i)
      (ccl == edge_timer_pkg::CLR_BOTH && (rise_ev || fall_ev))
         |=> count_q == 8'h00)
      else $error("counter not cleared by capture edge");
   ovf_high_a: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i)
      (ovf_ev && cap_en && cap_filt) |=> mode_q[7]
         && (!mode_q[6] || $past(mode_q[6])))
      else $error("high overflow flag not set");
   ovf_low_a: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i)
      (ovf_ev && !cap_en) |=> mode_q[6])
      else $error("low overflow flag not set in interval mode");
   flag_noset_a: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i)
      (!ovf_ev && !mode_q[7]) |=> !mode_q[7])
      else $error("high overflow flag set without overflow");
   timer_req_a: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i)
      (ovf_ev && mode_q[5]) |=> irq_stat_q[0]
         ##1 (irq_o || !$past(irq_mask_q[0])))
      else $error("overflow request not raised");
   bus_answer_a: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i)
      $rose(read_i) && waitrequest_o |=> !waitrequest_o ##1 waitrequest_o)
      else $error("bus answer not one cycle");
endmodule

// ### test/edge_capture_timer8_test.sv
// Self-checking bench: register access, capture, clear modes, overflow
// flags, interrupt, noise filter, standby and low power.
// Assumes the pulse source model drives the capture pin.
`timescale 1ns/10ps
module edge_capture_timer8_test;
   logic        core_clk;
   logic        rst_n;
   logic [17:0] address;
   logic        read;
   logic        write;
   logic [31:0] writedata;
   logic [31:0] readdata;
   logic        waitrequest;
   logic        pin;
   logic        watch_clk;
   logic        low_power;
   logic        irq;
   logic        start;
   logic [15:0] high_len;
   logic [15:0] low_len;
   logic        busy;
   logic [31:0] v;
   logic [31:0] r;
   logic [7:0]  rv;
   int          n_mismatch;
   int          num_checks;
   // Sys clocks per count for each clock code; watch clock is 4 sys clocks
   int          div[4] = '{64, 32, 2, 16};
   logic [31:0] clr_mode[3] = '{32'h06, 32'h0E, 32'h02};

   edge_capture_timer8 edge_capture_timer8_i (
      .core_clk_i          (core_clk),
      .rst_n_i             (rst_n),
      .address_i           (address),
      .read_i              (read),
      .write_i             (write),
      .byteenable_i        (4'hF),
      .writedata_i         (writedata),
      .readdata_o          (readdata),
      .waitrequest_o       (waitrequest),
      .capture_input_pin_i (pin),
      .watch_clk_i         (watch_clk),
      .low_power_i         (low_power),
      .irq_o               (irq)
   );

   pulse_source pulse_source_i (
      .core_clk_i (core_clk),
      .rst_n_i    (rst_n),
      .start_i    (start),
      .high_len_i (high_len),
      .low_len_i  (low_len),
      .busy_o     (busy),
      .pin_o      (pin)
   );

   // System clock and a free-running, unrelated watch clock
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   initial begin
      watch_clk = 1'b0;
      forever #10 watch_clk = ~watch_clk;
   end

   task automatic test_done();
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One Avalon access, held until waitrequest is seen low
   task automatic bus(input logic wr_en, input logic [15:0] idx,
                      input logic [31:0] wd, output logic [31:0] rdd);
      int n;
      n = 0;
      @(posedge core_clk);
      address   <= {idx, 2'b00};
      read      <= ~wr_en;
      write     <= wr_en;
      writedata <= wd;
      do begin
         @(posedge core_clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 20);
      rdd = readdata;
      read  <= 1'b0;
      write <= 1'b0;
      if (waitrequest !== 1'b0) begin
         n_mismatch++;
         test_done();
      end
   endtask

   task automatic wr(input logic [15:0] i, input logic [31:0] d);
      bus(1'b1, i, d, r);
   endtask
   task automatic rd(input logic [15:0] i);
      bus(1'b0, i, 32'h0, v);
   endtask
   task automatic rdchk(input logic [15:0] i, input logic [31:0] e);
      rd(i);
      chk(v, e);
   endtask
   // Captured count of about twenty, allowing prescaler phase
   task automatic rng(input logic [7:0] x);
      chk({31'h0, x >= 8'h12 && x <= 8'h17}, 32'h1);
   endtask

   task automatic go(input logic [15:0] hi, input logic [15:0] lo);
      @(posedge core_clk);
      start    <= 1'b1;
      high_len <= hi;
      low_len  <= lo;
      @(posedge core_clk);
      start <= 1'b0;
   endtask
   // Waits for the pulse to end, then lets the capture pipeline settle
   task automatic finish();
      int n;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (busy !== 1'b0 && n < 4000);
      if (busy !== 1'b0) begin
         n_mismatch++;
         test_done();
      end
      repeat (30) @(posedge core_clk);
   endtask

   initial begin
      rst_n      = 1'b0;
      read       = 1'b0;
      write      = 1'b0;
      address    = 18'h00000;
      writedata  = 32'h0;
      low_power  = 1'b0;
      start      = 1'b0;
      high_len   = 16'h0000;
      low_len    = 16'h0000;
      n_mismatch = 0;
      num_checks = 0;
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      // Reset values, unmapped read, read-only and flag writes
      rdchk(edge_timer_pkg::IDX_MODE_CTRL, 32'h00);
      rdchk(edge_timer_pkg::IDX_FALL_VALUE, 32'h00);
      rdchk(edge_timer_pkg::IDX_CLK_STOP1, 32'hFF);
      rdchk(16'h0123, 32'h00);
      wr(edge_timer_pkg::IDX_RISE_VALUE, 32'h5A);
      rdchk(edge_timer_pkg::IDX_RISE_VALUE, 32'h00);
      wr(edge_timer_pkg::IDX_MODE_CTRL, 32'hC0);
      rdchk(edge_timer_pkg::IDX_MODE_CTRL, 32'h00);
      // Interval operation ignores the pin
      go(16'h000A, 16'h000A);
      finish();
      rdchk(edge_timer_pkg::IDX_IRQ_STATUS, 32'h0);
      // Every clock code, clearing on rise, counting the high time
      wr(edge_timer_pkg::IDX_PORT_CTRL, 32'h1);
      for (int i = 0; i < 4; i++) begin
         wr(edge_timer_pkg::IDX_MODE_CTRL,
            {28'h0, edge_timer_pkg::CLR_RISE, i[1:0]});
         go(16'(20 * div[i]), 16'h0014);
         finish();
         rd(edge_timer_pkg::IDX_FALL_VALUE);
         rng(v[7:0]);
      end
      // Clear on fall, on both edges, or not at all, with chained pulses
      for (int k = 0; k < 3; k++) begin
         wr(edge_timer_pkg::IDX_MODE_CTRL, clr_mode[k]);
         go(16'h0028, 16'h0028);
         finish();
         go(16'h0028, 16'h0028);
         finish();
         rd(edge_timer_pkg::IDX_RISE_VALUE);
         rv = v[7:0];
         rd(edge_timer_pkg::IDX_FALL_VALUE);
         rng((k == 1) ? v[7:0] : v[7:0] - rv);
         // Clear on fall: the rise value is the low gap of about 36
         if (k == 0) begin
            chk({31'h0, rv >= 8'h20 && rv <= 8'h2F}, 32'h1);
         end
      end
      // Falling edge selected for the request, then rising
      wr(edge_timer_pkg::IDX_IRQ_MASK, 32'h1);
      wr(edge_timer_pkg::IDX_IRQ_STATUS, 32'h7);
      wr(edge_timer_pkg::IDX_MODE_CTRL, 32'h12);
      go(16'h003C, 16'h0014);
      repeat (20) @(posedge core_clk);
      rdchk(edge_timer_pkg::IDX_IRQ_STATUS, 32'h2);
      chk({31'h0, irq}, 32'h0);
      finish();
      rdchk(edge_timer_pkg::IDX_IRQ_STATUS, 32'h7);
      chk({31'h0, irq}, 32'h1);
      wr(edge_timer_pkg::IDX_IRQ_MASK, 32'h0);
      repeat (3) @(posedge core_clk);
      chk({31'h0, irq}, 32'h0);
      wr(edge_timer_pkg::IDX_IRQ_STATUS, 32'h7);
      rdchk(edge_timer_pkg::IDX_IRQ_STATUS, 32'h0);
      wr(edge_timer_pkg::IDX_MODE_CTRL, 32'h02);
      go(16'h003C, 16'h0014);
      repeat (20) @(posedge core_clk);
      rdchk(edge_timer_pkg::IDX_IRQ_STATUS, 32'h3);
      finish();
      // Counter cleared by a rise, then a wrap in interval operation;
      // the read arms any older flag so the write clears it first
      rd(edge_timer_pkg::IDX_MODE_CTRL);
      wr(edge_timer_pkg::IDX_MODE_CTRL, 32'h2A);
      go(16'h0002, 16'h0002);
      finish();
      wr(edge_timer_pkg::IDX_PORT_CTRL, 32'h0);
      wr(edge_timer_pkg::IDX_IRQ_STATUS, 32'h7);
      repeat (600) @(posedge core_clk);
      rdchk(edge_timer_pkg::IDX_MODE_CTRL, 32'h6A);
      rdchk(edge_timer_pkg::IDX_IRQ_STATUS, 32'h1);
      wr(edge_timer_pkg::IDX_MODE_CTRL, 32'h2A);
      rdchk(edge_timer_pkg::IDX_MODE_CTRL, 32'h2A);
      // Wrap while the pin is high
      wr(edge_timer_pkg::IDX_PORT_CTRL, 32'h1);
      go(16'h02BC, 16'h0002);
      finish();
      rdchk(edge_timer_pkg::IDX_MODE_CTRL, 32'hAA);
      // Filter drops a short glitch and passes a long pulse
      wr(edge_timer_pkg::IDX_MODE_CTRL, 32'h02);
      wr(edge_timer_pkg::IDX_PORT_CTRL, 32'h3);
      repeat (30) @(posedge core_clk);
      wr(edge_timer_pkg::IDX_IRQ_STATUS, 32'h7);
      go(16'h0006, 16'h0014);
      finish();
      rdchk(edge_timer_pkg::IDX_IRQ_STATUS, 32'h0);
      go(16'h0028, 16'h0028);
      finish();
      rdchk(edge_timer_pkg::IDX_IRQ_STATUS, 32'h7);
      // Standby stops capture
      wr(edge_timer_pkg::IDX_PORT_CTRL, 32'h1);
      repeat (30) @(posedge core_clk);
      wr(edge_timer_pkg::IDX_IRQ_STATUS, 32'h7);
      wr(edge_timer_pkg::IDX_CLK_STOP1, 32'hF7);
      rdchk(edge_timer_pkg::IDX_CLK_STOP1, 32'hF7);
      go(16'h0014, 16'h0014);
      finish();
      rdchk(edge_timer_pkg::IDX_IRQ_STATUS, 32'h0);
      wr(edge_timer_pkg::IDX_CLK_STOP1, 32'hFF);
      // Low power with a system-derived clock: counter frozen
      low_power <= 1'b1;
      go(16'h0028, 16'h0014);
      finish();
      rd(edge_timer_pkg::IDX_RISE_VALUE);
      rv = v[7:0];
      rd(edge_timer_pkg::IDX_FALL_VALUE);
      chk({24'h0, rv}, v);
      low_power <= 1'b0;
      test_done();
   end
endmodule

// ### test/pulse_source.sv
// Behavioural model of the external pulse source on the capture pin.
// Assumes start_i is a one-cycle request given while busy_o is low.
`timescale 1ns/10ps
module pulse_source (
   // Clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        rst_n_i,
   // Requests from the bench
   input  wire logic        start_i,
   input  wire logic [15:0] high_len_i,
   input  wire logic [15:0] low_len_i,
   output logic             busy_o,
   // Capture pin, idle low
   output logic             pin_o
);
   logic [15:0] left_q;

   // One high pulse, then a low gap; busy drops when the gap is over.
   // Levels are never shorter than two clocks, or edges could be lost.
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         busy_o <= 1'b0;
         pin_o  <= 1'b0;
         left_q <= 16'h0000;
      end else if (start_i && !busy_o) begin
         busy_o <= 1'b1;
         pin_o  <= 1'b1;
         left_q <= (high_len_i < 16'h0002) ? 16'h0002 : high_len_i;
      end else if (busy_o) begin
         if (left_q > 16'h0001) begin
            left_q <= left_q - 16'h0001;
         end else if (pin_o) begin
            pin_o  <= 1'b0;
            left_q <= (low_len_i < 16'h0002) ? 16'h0002 : low_len_i;
         end else begin
            busy_o <= 1'b0;
         end
      end
   end
endmodule
